// >>> inc/nvc_pkg.sv
/*
  nvc_pkg: constants, command codes and carrier types for the nvm command control block.
  assumes a 32-bit apb slave with one register per aligned word.
*/
package nvc_pkg;

  // register indices and byte addresses
  localparam logic [7:0] NVC_IDX_COMMAND = 8'h00;
  localparam logic [7:0] NVC_IDX_MAPCTL  = 8'h01;
  localparam logic [7:0] NVC_IDX_STATUS  = 8'h02;
  localparam logic [7:0] NVC_IDX_INTEN   = 8'h03;
  localparam logic [7:0] NVC_IDX_INTFLG  = 8'h04;
  localparam logic [7:0] NVC_IDX_RSVD    = 8'h05;
  localparam logic [7:0] NVC_IDX_DATA    = 8'h06;
  localparam logic [7:0] NVC_IDX_ADDR    = 8'h08;
  localparam logic [7:0] NVC_IDX_CCP     = 8'h0a;
  localparam logic [7:0] NVC_IDX_SYS     = 8'h0b;
  localparam int         NVC_ADDR_SHIFT  = 2;

  // reset values
  localparam logic [7:0] NVC_MAPCTL_RST  = 8'h30;
  localparam logic [1:0] NVC_MAP_RST     = 2'h3;

  // field positions in map_protect_control
  localparam int NVC_B_LOCK   = 7;
  localparam int NVC_B_MAP_HI = 5;
  localparam int NVC_B_MAP_LO = 4;
  localparam int NVC_B_DATAWP = 2;
  localparam int NVC_B_BOOT_READ_PROTECT = 1;
  localparam int NVC_B_CODEWP = 0;

  // status fields
  localparam int NVC_B_ERR_HI = 6;
  localparam int NVC_B_ERR_LO = 4;
  localparam int NVC_B_EEPROM_BUSY = 1;
  localparam int NVC_B_FLASH_BUSY  = 0;

  // change protection keys (values arbitrary)
  localparam logic [7:0] NVC_KEY_SPM   = 8'h9d;
  localparam logic [7:0] NVC_KEY_IO_REGISTER_KEY = 8'hd8;
  localparam logic [2:0] NVC_CCP_WINDOW = 3'h4;

  // error codes
  localparam logic [2:0] NVC_ERR_NONE      = 3'h0;
  localparam logic [2:0] NVC_ERR_INVALID   = 3'h1;
  localparam logic [2:0] NVC_ERR_WRPROT    = 3'h2;
  localparam logic [2:0] NVC_ERR_COLLISION = 3'h3;

  // command codes
  localparam logic [6:0] NVC_NO_COMMAND   = 7'h00;
  localparam logic [6:0] NVC_NO_OPERATION = 7'h01;
  localparam logic [6:0] NVC_FLASH_WR     = 7'h02;
  localparam logic [6:0] NVC_FLASH_PER    = 7'h08;
  localparam logic [6:0] NVC_FLASH_PER32  = 7'h0d;
  localparam logic [6:0] NVC_EE_WR        = 7'h12;
  localparam logic [6:0] NVC_EE_ERWR      = 7'h13;
  localparam logic [6:0] NVC_EE_BER       = 7'h18;
  localparam logic [6:0] NVC_EE_BER32     = 7'h1d;
  localparam logic [6:0] NVC_CHIP_ERASE   = 7'h20;
  localparam logic [6:0] NVC_EE_FULL      = 7'h30;

  // op kinds sent to the array sequencer
  typedef enum logic [3:0] {
    NVC_OP_FLASH_WR = 4'b0001,
    NVC_OP_FLASH_ER = 4'b0010,
    NVC_OP_EE_WR    = 4'b0100,
    NVC_OP_EE_ER    = 4'b1000
  } nvc_op_t;

  // store request from the cpu
  typedef struct packed {
    logic        valid;
    logic        ee;
    logic        boot_sec;
    logic        data_sec;
    logic [23:0] addr;
    logic [15:0] data;
  } nvc_store_t;

  // operation start to the array sequencer
  typedef struct packed {
    logic        start;
    logic [6:0]  cmd;
    logic        skip_ee;
    logic [23:0] addr;
    logic [15:0] data;
  } nvc_start_t;

  // sleep power state
  typedef enum logic [2:0] {
    NVC_AWAKE = 3'b001,
    NVC_DRAIN = 3'b010,
    NVC_ASLEEP = 3'b100
  } nvc_pwr_t;

endpackage

// >>> rtl/nvc_ctrl.sv
/*
  nvc_ctrl: command, mapping/protection, status and ready-interrupt front end of the nvm controller.
  assumes an apb master on ref_clk, a cpu side giving store requests and key writes on the same clock,
  and an array sequencer reporting busy levels from another domain.
*/
// Design decision made here: the APB slave port.
// Operation
// - idle eeprom sets ready flag
// - enable bit gates ready interrupt
// - irq while enabled and flag set
// - controller sleeps with system if idle
// - pending eeprom op keeps clock until done
// - ready wakes only from idle sleep
// - unlocked write leaves protected register unchanged
// - command uses spm key, mapctl io key
// - chip erase and full eeprom erase start on write, others arm
// - flash command codes decoded
// - eeprom command codes decoded
// - chip erase debug only, full eeprom erase
// - mapping lock freezes map until reset
// - map field selects section, resets three
// - map field writes need no unlock
// - app data protect sticky until reset
// - boot read protect blanks reads, nop fetch
// - boot protect writable only from boot
// - app code protect sticky until reset
// - error field holds last error, clear zero
// - ready flag set while idle, w1c
module nvc_ctrl
  import nvc_pkg::*;
(
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // cpu side
  input  wire nvc_pkg::nvc_store_t store_req,
  input  wire logic               fetch_in_boot,
  input  wire logic               from_debug_port,
  input  wire logic               eeprom_save_fuse,
  input  wire logic               sys_sleep,
  input  wire logic               sleep_is_idle,
  // array sequencer (async busy levels)
  input  wire logic               flash_busy_async,
  input  wire logic               eeprom_busy_async,
  output nvc_pkg::nvc_start_t     op_start,
  output logic [1:0]              flash_section_map,
  output logic                    boot_read_protect,
  output logic                    boot_fetch_nop,
  output logic                    irq,
  output logic                    wake_req,
  output logic                    clk_keep_on
);

  // reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn) rst_sync_q <= 2'b00;
    else         rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // busy synchronisers
  logic [1:0] fb_sync_q, eb_sync_q;
  logic       flash_busy, eeprom_busy;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fb_sync_q <= 2'b00;
      eb_sync_q <= 2'b00;
    end
    else
    begin
      fb_sync_q <= {fb_sync_q[0], flash_busy_async};
      eb_sync_q <= {eb_sync_q[0], eeprom_busy_async};
    end
  end
  assign flash_busy  = fb_sync_q[1];
  assign eeprom_busy = eb_sync_q[1];

  function automatic logic cmd_is_arm(input logic [6:0] c);
    return (c == NVC_FLASH_WR) ||
           (c >= NVC_FLASH_PER && c <= NVC_FLASH_PER32) ||
           (c == NVC_EE_WR) || (c == NVC_EE_ERWR) ||
           (c >= NVC_EE_BER && c <= NVC_EE_BER32);
  endfunction

  function automatic logic cmd_is_ee(input logic [6:0] c);
    return (c == NVC_EE_WR) || (c == NVC_EE_ERWR) || (c >= NVC_EE_BER && c <= NVC_EE_BER32);
  endfunction

  function automatic logic cmd_is_idle(input logic [6:0] c);
    return (c == NVC_NO_COMMAND) || (c == NVC_NO_OPERATION);
  endfunction

  // apb decode
  logic       wr_en, rd_en;
  logic [7:0] idx;
  logic [7:0] wb;
  // writes land once, at the edge that completes the access
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite;
  assign idx   = paddr[NVC_ADDR_SHIFT +: 8];
  assign wb    = pwdata[7:0];

  // change protection window
  logic [7:0] key_q;
  logic [2:0] ccp_cnt_q;
  logic       spm_open, io_open;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_q     <= 8'h00;
      ccp_cnt_q <= 3'h0;
    end
    else if (wr_en && idx == NVC_IDX_CCP)
    begin
      key_q     <= wb;
      ccp_cnt_q <= NVC_CCP_WINDOW;
    end
    else if (ccp_cnt_q != 3'h0)
      ccp_cnt_q <= ccp_cnt_q - 3'h1;
  end
  assign spm_open = (ccp_cnt_q != 3'h0) && (key_q == NVC_KEY_SPM);
  assign io_open  = (ccp_cnt_q != 3'h0) && (key_q == NVC_KEY_IO_REGISTER_KEY);

  // command register and operation start
  logic [6:0] cmd_q;
  logic [2:0] err_q;
  logic       cmd_wr, store_blocked;
  logic [7:0] map_q;
  nvc_start_t op_q;
  assign cmd_wr = wr_en && idx == NVC_IDX_COMMAND && spm_open;
  assign store_blocked = (store_req.boot_sec && 1'b0) ||
                         (!store_req.ee && !store_req.data_sec && map_q[NVC_B_CODEWP]) ||
                         (!store_req.ee && store_req.data_sec && map_q[NVC_B_DATAWP]);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_q <= NVC_NO_COMMAND;
    else if (cmd_wr)
      cmd_q <= wb[6:0];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      op_q <= '0;
    else
    begin
      op_q.start <= 1'b0;
      if (cmd_wr && wb[6:0] == NVC_EE_FULL)
      begin
        op_q.start   <= 1'b1;
        op_q.cmd     <= NVC_EE_FULL;
        op_q.skip_ee <= 1'b0;
      end
      else if (cmd_wr && wb[6:0] == NVC_CHIP_ERASE && from_debug_port)
      begin
        op_q.start   <= 1'b1;
        op_q.cmd     <= NVC_CHIP_ERASE;
        op_q.skip_ee <= eeprom_save_fuse;
      end
      else if (store_req.valid && cmd_is_arm(cmd_q) && !store_blocked &&
               (cmd_is_ee(cmd_q) == store_req.ee))
      begin
        op_q.start   <= 1'b1;
        op_q.cmd     <= cmd_q;
        op_q.skip_ee <= 1'b0;
        op_q.addr    <= store_req.addr;
        op_q.data    <= store_req.data;
      end
    end
  end

  // error field: hardware error wins over software clear
  logic [2:0] err_d;
  always_comb
  begin
    err_d = err_q;
    if (wr_en && idx == NVC_IDX_STATUS && wb[NVC_B_ERR_HI:NVC_B_ERR_LO] == NVC_ERR_NONE)
      err_d = NVC_ERR_NONE;
    if (store_req.valid && cmd_is_arm(cmd_q) && store_blocked)
      err_d = NVC_ERR_WRPROT;
    if (cmd_wr)
    begin
      if (!(cmd_is_arm(wb[6:0]) || cmd_is_idle(wb[6:0]) || wb[6:0] == NVC_EE_FULL ||
            (wb[6:0] == NVC_CHIP_ERASE && from_debug_port)))
        err_d = NVC_ERR_INVALID;
      else if (!cmd_is_idle(cmd_q) && !cmd_is_idle(wb[6:0]))
        err_d = NVC_ERR_COLLISION;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n) err_q <= NVC_ERR_NONE;
    else        err_q <= err_d;
  end

  // map/protect register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      map_q <= NVC_MAPCTL_RST;
    else if (wr_en && idx == NVC_IDX_MAPCTL)
    begin
      if (!map_q[NVC_B_LOCK])
        map_q[NVC_B_MAP_HI:NVC_B_MAP_LO] <= wb[NVC_B_MAP_HI:NVC_B_MAP_LO];
      if (io_open)
      begin
        map_q[NVC_B_LOCK]   <= map_q[NVC_B_LOCK]   | wb[NVC_B_LOCK];
        map_q[NVC_B_DATAWP] <= map_q[NVC_B_DATAWP] | wb[NVC_B_DATAWP];
        map_q[NVC_B_CODEWP] <= map_q[NVC_B_CODEWP] | wb[NVC_B_CODEWP];
        if (fetch_in_boot)
          map_q[NVC_B_BOOT_READ_PROTECT] <= map_q[NVC_B_BOOT_READ_PROTECT] | wb[NVC_B_BOOT_READ_PROTECT];
      end
    end
  end

  // interrupt enable and ready flag
  logic inten_q, rdy_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      inten_q <= 1'b0;
    else if (wr_en && idx == NVC_IDX_INTEN)
      inten_q <= wb[0];
  end
  // idle level sets the flag and wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdy_q <= 1'b0;
    else if (!eeprom_busy && !op_q.start)
      rdy_q <= 1'b1;
    else if (wr_en && idx == NVC_IDX_INTFLG && wb[0])
      rdy_q <= 1'b0;
  end

  // data and address
  logic [15:0] data_q;
  logic [23:0] addr_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_q <= 16'h0000;
      addr_q <= 24'h000000;
    end
    else
    begin
      if (wr_en && idx == NVC_IDX_DATA) data_q <= pwdata[15:0];
      if (wr_en && idx == NVC_IDX_ADDR) addr_q <= pwdata[23:0];
    end
  end

  // sleep control
  nvc_pwr_t pwr_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pwr_q <= NVC_AWAKE;
    else
      unique case (pwr_q)
        NVC_AWAKE:
          if (sys_sleep)
            pwr_q <= eeprom_busy ? NVC_DRAIN : NVC_ASLEEP;
        NVC_DRAIN:
          if (!sys_sleep)        pwr_q <= NVC_AWAKE;
          else if (!eeprom_busy) pwr_q <= NVC_ASLEEP;
        NVC_ASLEEP:
          if (!sys_sleep) pwr_q <= NVC_AWAKE;
      endcase
  end

  // read data select, registered into prdata below
  logic [31:0] rd_d;
  always_comb
  begin
    rd_d = 32'h0;
    unique case (idx)
      NVC_IDX_COMMAND: rd_d[6:0]  = cmd_q;
      NVC_IDX_MAPCTL:  rd_d[7:0]  = map_q & 8'hb7;
      NVC_IDX_STATUS:  rd_d[7:0]  = {1'b0, err_q, 2'b00, eeprom_busy, flash_busy};
      NVC_IDX_INTEN:   rd_d[0]    = inten_q;
      NVC_IDX_INTFLG:  rd_d[0]    = rdy_q;
      NVC_IDX_DATA:    rd_d[15:0] = data_q;
      NVC_IDX_ADDR:    rd_d[23:0] = addr_q;
      default:         rd_d       = 32'h0;
    endcase
  end

  // apb answer: one wait state keeps read data straight from a flop
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      prdata  <= rd_en ? rd_d : 32'h0;
      pslverr <= 1'b0;
    end
  end

  // operation start to the array sequencer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      op_start <= '0;
    else
      op_start <= op_q;
  end

  // mapping and boot protection outputs
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_section_map <= NVC_MAP_RST;
      boot_read_protect <= 1'b0;
      boot_fetch_nop    <= 1'b0;
    end
    else
    begin
      flash_section_map <= map_q[NVC_B_MAP_HI:NVC_B_MAP_LO];
      // protection only once execution has left the boot section
      boot_read_protect <= map_q[NVC_B_BOOT_READ_PROTECT] && !fetch_in_boot;
      boot_fetch_nop    <= map_q[NVC_B_BOOT_READ_PROTECT] && !fetch_in_boot;
    end
  end

  // ready interrupt and wake request
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq      <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      irq      <= inten_q && rdy_q;
      // deeper sleep modes have no clock to take the wake
      wake_req <= inten_q && rdy_q && sys_sleep && sleep_is_idle;
    end
  end

  // peripheral clock request, held while an eeprom op drains
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      clk_keep_on <= 1'b1;
    else
      clk_keep_on <= (pwr_q != NVC_ASLEEP);
  end

endmodule

// >>> testbench/nvc_cpu_model.sv
/*
  nvc_cpu_model: cpu store issuer for nvc_ctrl.
  assumes ref_clk and that stores are spaced by the caller.
*/
module nvc_cpu_model
  import nvc_pkg::*;
(
  // clock
  input wire logic            ref_clk,
  // store port
  output nvc_pkg::nvc_store_t store_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial store_req = '0;
  // one-cycle pulse per store
  task automatic store(input logic ee, input logic dsec);
    @(posedge ref_clk);
    store_req <= '{1'b1, ee, 1'b0, dsec, 24'h000040, 16'h00a5};
    @(posedge ref_clk);
    store_req.valid <= 1'b0;
  endtask
endmodule

// >>> testbench/nvc_ctrl_chk.sv
/*
  nvc_ctrl_chk: port-level assertions on nvc_ctrl.
  assumes it is bound to nvc_ctrl and sees nvc_pkg.
*/
module nvc_ctrl_chk
  import nvc_pkg::*;
(
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                resetn,
  // inputs
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic                sys_sleep,
  input wire logic                sleep_is_idle,
  input wire logic                eeprom_busy_async,
  // outputs
  input wire logic                pslverr,
  input wire nvc_pkg::nvc_start_t op_start,
  input wire logic [1:0]          flash_section_map,
  input wire logic                boot_read_protect,
  input wire logic                boot_fetch_nop,
  input wire logic                irq,
  input wire logic                wake_req,
  input wire logic                clk_keep_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_wake;
    wake_req |-> $past(sys_sleep) && $past(sleep_is_idle);
  endproperty
  a_wake: assert property (p_wake) else $error("wake outside idle sleep");
  property p_off;
    !clk_keep_on |-> $past(sys_sleep) || $past(sys_sleep, 2);
  endproperty
  a_off: assert property (p_off) else $error("clock off while awake");
  // busy synchroniser needs a few cycles of history
  property p_busy;
    $rose(sys_sleep) && eeprom_busy_async && $past(eeprom_busy_async, 3) |-> clk_keep_on [*4];
  endproperty
  a_busy: assert property (p_busy) else $error("clock dropped with eeprom busy");
  property p_map;
    !$past(psel && penable && pwrite, 2) |-> $stable(flash_section_map);
  endproperty
  a_map: assert property (p_map) else $error("map moved without write");
  property p_start;
    op_start.start |=> !op_start.start;
  endproperty
  a_start: assert property (p_start) else $error("start longer than a pulse");
  property p_err;
    psel |-> !pslverr;
  endproperty
  a_err: assert property (p_err) else $error("slave error raised");
  property p_nop;
    boot_fetch_nop |-> boot_read_protect;
  endproperty
  a_nop: assert property (p_nop) else $error("nop fetch without protect");
  property p_rp;
    boot_read_protect |=> boot_read_protect;
  endproperty
  a_rp: assert property (p_rp) else $error("boot protect cleared");
  property p_irq;
    $fell(irq) |-> $past(psel && pwrite, 2) || $past(psel && pwrite, 3);
  endproperty
  a_irq: assert property (p_irq) else $error("irq fell without write");
  c_start: cover property (op_start.start);
  c_wake: cover property (wake_req);
  c_off: cover property ($fell(clk_keep_on));
endmodule

bind nvc_ctrl nvc_ctrl_chk i_chk (.ref_clk, .resetn, .psel, .penable, .pwrite, .sys_sleep, .sleep_is_idle,
  .eeprom_busy_async, .pslverr, .op_start, .flash_section_map, .boot_read_protect, .boot_fetch_nop, .irq,
  .wake_req, .clk_keep_on);

// >>> testbench/tb.sv
/*
  tb: self-checking bench for nvc_ctrl over apb.
  assumes nvc_pkg, nvc_ctrl, nvc_cpu_model and the bound checker.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nvc_pkg::*;
  logic        ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, q;
  logic        from_debug_port = 1'b0, fetch_in_boot = 1'b0, eeprom_save_fuse = 1'b1, flash_busy_async = 1'b0;
  logic        sys_sleep = 1'b0, sleep_is_idle = 1'b0, eeprom_busy_async = 1'b0;
  logic [7:0]  last = 8'h00;
  logic [6:0]  codes [15] = '{7'h02, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h12, 7'h13, 7'h18, 7'h19,
                             7'h1a, 7'h1b, 7'h1c, 7'h1d};
  int          failures = 0, n_tests = 0, starts = 0;
  wire logic   pready, pslverr, boot_read_protect, boot_fetch_nop, irq, wake_req, clk_keep_on;
  wire logic [31:0] prdata;
  wire logic [1:0]  flash_section_map;
  wire nvc_store_t  store_req;
  wire nvc_start_t  op_start;

  nvc_ctrl i_dut (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .store_req, .fetch_in_boot, .from_debug_port, .eeprom_save_fuse, .sys_sleep, .sleep_is_idle,
    .flash_busy_async, .eeprom_busy_async, .op_start, .flash_section_map, .boot_read_protect, .boot_fetch_nop,
    .irq, .wake_req, .clk_keep_on);
  nvc_cpu_model i_cpu (.ref_clk, .store_req);

  initial forever #10 ref_clk = ~ref_clk;
  // counting pulses catches doubles and missing starts alike
  always @(posedge ref_clk)
    if (op_start.start === 1'b1)
    begin
      starts <= starts + 1;
      last <= {op_start.skip_ee, op_start.cmd};
    end

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk(q, e);
  endtask
  // key then target, four cycles apart
  task automatic kw(input logic [7:0] k, input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, NVC_IDX_CCP, {24'h0, k});
    apb(1'b1, i, d);
  endtask
  task automatic ck_start(input int n, input logic [6:0] c);
    repeat (6) @(posedge ref_clk);
    chk(starts, n);
    chk({25'h0, last[6:0]}, {25'h0, c});
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(NVC_IDX_MAPCTL, 32'h30);
    rd(NVC_IDX_COMMAND, 32'h0);
    chk(flash_section_map, 32'h3);
    apb(1'b1, NVC_IDX_COMMAND, 32'h12);
    rd(NVC_IDX_COMMAND, 32'h0);
    kw(NVC_KEY_IO_REGISTER_KEY, NVC_IDX_COMMAND, 32'h12);
    rd(NVC_IDX_COMMAND, 32'h0);
    foreach (codes[i])
    begin
      kw(NVC_KEY_SPM, NVC_IDX_COMMAND, 32'h0);
      kw(NVC_KEY_SPM, NVC_IDX_COMMAND, {25'h0, codes[i]});
      rd(NVC_IDX_COMMAND, {25'h0, codes[i]});
      i_cpu.store(codes[i][4], 1'b0);
      ck_start(i + 1, codes[i]);
      rd(NVC_IDX_STATUS, 32'h0);
    end
    kw(NVC_KEY_SPM, NVC_IDX_COMMAND, 32'h1);
    kw(NVC_KEY_SPM, NVC_IDX_COMMAND, 32'h30);
    ck_start(16, 7'h30);
    kw(NVC_KEY_SPM, NVC_IDX_COMMAND, 32'h0);
    kw(NVC_KEY_SPM, NVC_IDX_COMMAND, 32'h20);
    rd(NVC_IDX_STATUS, 32'h10);
    apb(1'b1, NVC_IDX_STATUS, 32'h0);
    rd(NVC_IDX_STATUS, 32'h0);
    from_debug_port <= 1'b1;
    kw(NVC_KEY_SPM, NVC_IDX_COMMAND, 32'h0);
    kw(NVC_KEY_SPM, NVC_IDX_COMMAND, 32'h20);
    ck_start(17, 7'h20);
    chk(last[7], 32'h1);
    kw(NVC_KEY_SPM, NVC_IDX_COMMAND, 32'h0);
    kw(NVC_KEY_SPM, NVC_IDX_COMMAND, 32'h12);
    kw(NVC_KEY_SPM, NVC_IDX_COMMAND, 32'h08);
    rd(NVC_IDX_STATUS, 32'h30);
    apb(1'b1, NVC_IDX_MAPCTL, 32'h0);
    rd(NVC_IDX_MAPCTL, 32'h0);
    kw(NVC_KEY_IO_REGISTER_KEY, NVC_IDX_MAPCTL, 32'h80);
    apb(1'b1, NVC_IDX_MAPCTL, 32'h30);
    rd(NVC_IDX_MAPCTL, 32'h80);
    chk(flash_section_map, 32'h0);
    kw(NVC_KEY_IO_REGISTER_KEY, NVC_IDX_MAPCTL, 32'hcf);
    rd(NVC_IDX_MAPCTL, 32'h85);
    kw(NVC_KEY_IO_REGISTER_KEY, NVC_IDX_MAPCTL, 32'h80);
    rd(NVC_IDX_MAPCTL, 32'h85);
    fetch_in_boot <= 1'b1;
    kw(NVC_KEY_IO_REGISTER_KEY, NVC_IDX_MAPCTL, 32'h82);
    fetch_in_boot <= 1'b0;
    rd(NVC_IDX_MAPCTL, 32'h87);
    chk(boot_read_protect, 32'h1);
    chk(boot_fetch_nop, 32'h1);
    kw(NVC_KEY_SPM, NVC_IDX_COMMAND, 32'h0);
    apb(1'b1, NVC_IDX_STATUS, 32'h0);
    kw(NVC_KEY_SPM, NVC_IDX_COMMAND, 32'h02);
    i_cpu.store(1'b0, 1'b1);
    ck_start(17, 7'h20);
    rd(NVC_IDX_STATUS, 32'h20);
    apb(1'b1, NVC_IDX_RSVD, 32'hff);
    rd(NVC_IDX_RSVD, 32'h0);
    rd(NVC_IDX_SYS, 32'h0);
    rd(NVC_IDX_INTFLG, 32'h1);
    apb(1'b1, NVC_IDX_INTEN, 32'h1);
    rd(NVC_IDX_INTEN, 32'h1);
    chk(irq, 32'h1);
    eeprom_busy_async <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b1, NVC_IDX_INTFLG, 32'h1);
    rd(NVC_IDX_INTFLG, 32'h0);
    rd(NVC_IDX_STATUS, 32'h22);
    chk(irq, 32'h0);
    sys_sleep <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(clk_keep_on, 32'h1);
    eeprom_busy_async <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(irq, 32'h1);
    chk(wake_req, 32'h0);
    chk(clk_keep_on, 32'h0);
    sleep_is_idle <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(wake_req, 32'h1);
    print_verdict();
  end
endmodule
